// >>> hw/slow_time_base_regs.vh
// Register map, field positions and reset values of the slow time base
`ifndef SLOW_TIME_BASE_REGS_VH
`define SLOW_TIME_BASE_REGS_VH

// Register indices, byte address is four times the index
`define IDX_TAP_SNAPSHOT 16'hf060
`define IDX_TRIM_LOW 16'hf062
`define IDX_TRIM_HIGH 16'hf063
`define IDX_IRQ_SEL_LOW 16'hf064
`define IDX_IRQ_SEL_HIGH 16'hf065
`define IDX_IRQ_STATUS 16'hf068
`define IDX_IRQ_CLEAR 16'hf069
`define IDX_IRQ_ENABLE 16'hf06a

// Reset values
`define RST_TRIM 11'h000
`define RST_IRQ_SEL_LOW 8'h30
`define RST_IRQ_SEL_HIGH 3'h6
`define RST_IRQ_ENABLE 3'h0

// Field positions
`define F_IRQ0_CODE 2:0
`define F_IRQ1_CODE 6:4
`define F_IRQ2_CODE 2:0
`define F_TRIM_HIGH 2:0

// Divider chain layout: upper chain bit 0 is the 8 kHz tap, bit 6 the 128 Hz tap
`define TAP_128_BIT 6
`define TAP_1_BIT 13
`define TRIM_FRAC_BITS 21

`endif

// >>> hw/slow_time_base.v
// Low-speed time base divider chain with trim, periodic interrupts and APB registers
// Function
// - Divide slow clock into 32 kHz..1 Hz taps
// - Count up from zero after reset
// - Snapshot byte: 128 Hz bit0 to 1 Hz bit7
// - Snapshot write clears 128 Hz..1 Hz stages
// - Trim is 11 bits, upper bits unused
// - Trim field is two's complement
// - One trim count is 1/2097152 rate
// - Trim acts on 8 kHz and slower only
// - Three periodic interrupts from 128..1 Hz taps
// - Select fields at bits 2:0, 6:4, 10:8
// - Code 0 is 128 Hz, 7 is 1 Hz
// - Request on falling edge of tap
// - Forced tap fall raises request too
// - Select change may raise request
// - Request reaches controller one cycle later
//
// Added by the designer: the APB interface to the registers.
`include "slow_time_base_regs.vh"
`default_nettype none

module slow_time_base (
  // Clock and reset
  input wire CLK,
  input wire SRST,
  // Low-speed source clock, sampled on CLK
  input wire SLOW_CLK,
  // APB slave
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [19:0] PADDR,
  input wire [31:0] PWDATA,
  output wire PREADY,
  output wire PSLVERR,
  output reg [31:0] PRDATA,
  // Taps for peripherals
  output wire TAP_32K,
  output wire TAP_16K,
  output wire TAP_8K,
  // Periodic requests to the interrupt controller and summary interrupt
  output reg PERIODIC_IRQ0,
  output reg PERIODIC_IRQ1,
  output reg PERIODIC_IRQ2,
  output wire IRQ
);

  // Decodes a register index against the word address
  function hit;
    input [19:0] addr;
    input [15:0] idx;
    begin
      hit = (addr[19:18] == 2'h0) && (addr[17:2] == idx);
    end
  endfunction

  // Picks one of the eight slow taps by its 3-bit select code
  function tap_pick;
    input [13:0] chain;
    input [2:0] code;
    begin
      tap_pick = chain[`TAP_128_BIT + code];
    end
  endfunction

  // Divider state
  reg slow_q_r;
  reg stage16_r;
  reg [13:0] upper_r;
  reg [20:0] frac_r;
  reg [13:0] upper_nxt;
  reg [20:0] frac_nxt;
  reg [22:0] sum;

  // Software registers
  reg [10:0] trim_r;
  reg [7:0] sel_low_r;
  reg [2:0] sel_high_r;
  reg [2:0] enable_r;

  // Request detection and status
  reg [2:0] sel_tap_q_r;
  reg [2:0] cur_tap;
  reg [2:0] irq_nxt;
  reg [2:0] status_r;
  reg [2:0] status_nxt;

  // Read path
  reg [31:0] rd_word;

  // Bus phase decode
  wire setup_ph;
  wire acc_ok;
  wire wr;
  wire bad_addr;

  // One select line per register
  wire sel_snap;
  wire sel_trim_lo;
  wire sel_trim_hi;
  wire sel_int_lo;
  wire sel_int_hi;
  wire sel_stat;
  wire sel_clr;
  wire sel_en;

  // Write strobes
  wire snap_wr;
  wire trim_lo_wr;
  wire trim_hi_wr;
  wire int_lo_wr;
  wire int_hi_wr;
  wire clr_wr;
  wire en_wr;

  // Divider edges and taps
  wire slow_fall;
  wire tick16;
  wire [7:0] slow_taps;

  // Register selects from the word address
  assign sel_snap = hit(PADDR, `IDX_TAP_SNAPSHOT);
  assign sel_trim_lo = hit(PADDR, `IDX_TRIM_LOW);
  assign sel_trim_hi = hit(PADDR, `IDX_TRIM_HIGH);
  assign sel_int_lo = hit(PADDR, `IDX_IRQ_SEL_LOW);
  assign sel_int_hi = hit(PADDR, `IDX_IRQ_SEL_HIGH);
  assign sel_stat = hit(PADDR, `IDX_IRQ_STATUS);
  assign sel_clr = hit(PADDR, `IDX_IRQ_CLEAR);
  assign sel_en = hit(PADDR, `IDX_IRQ_ENABLE);

  // APB phases, zero wait state
  assign setup_ph = PSEL && !PENABLE;
  assign acc_ok = PSEL && PENABLE;
  assign wr = acc_ok && PWRITE;
  assign bad_addr = !(sel_snap || sel_trim_lo || sel_trim_hi || sel_int_lo ||
    sel_int_hi || sel_stat || sel_clr || sel_en);
  assign PREADY = 1'b1;
  assign PSLVERR = acc_ok && bad_addr; // Unmapped words refuse the access

  // Write strobes, one per register except the read-only status register
  assign snap_wr = wr && sel_snap;
  assign trim_lo_wr = wr && sel_trim_lo;
  assign trim_hi_wr = wr && sel_trim_hi;
  assign int_lo_wr = wr && sel_int_lo;
  assign int_hi_wr = wr && sel_int_hi;
  assign clr_wr = wr && sel_clr;
  assign en_wr = wr && sel_en;

  // Edge of the slow clock and the untrimmed 16 kHz stage wrapping
  assign slow_fall = slow_q_r && !SLOW_CLK;
  assign tick16 = slow_fall && stage16_r;

  // Taps for peripherals and the snapshot byte
  assign TAP_32K = slow_q_r;
  assign TAP_16K = stage16_r;
  assign TAP_8K = upper_r[0];
  assign slow_taps = upper_r[`TAP_1_BIT:`TAP_128_BIT];

  // Trimmed chain step: fractional accumulator adds or drops one 16 kHz step
  always @*
  begin
    sum = {2'h0, frac_r} + {{12{trim_r[10]}}, trim_r};
    upper_nxt = upper_r;
    frac_nxt = frac_r;
    if (tick16)
    begin
      frac_nxt = sum[20:0];
      if (sum[22])
      begin
        upper_nxt = upper_r;
      end
      else if (sum[21])
      begin
        upper_nxt = upper_r + 14'h0002;
      end
      else
      begin
        upper_nxt = upper_r + 14'h0001;
      end
    end
    if (snap_wr)
    begin
      upper_nxt = {8'h00, upper_nxt[5:0]};
    end
  end

  // Selected tap for each request after this cycle's chain update
  always @*
  begin
    cur_tap[0] = tap_pick(upper_nxt, sel_low_r[`F_IRQ0_CODE]);
    cur_tap[1] = tap_pick(upper_nxt, sel_low_r[`F_IRQ1_CODE]);
    cur_tap[2] = tap_pick(upper_nxt, sel_high_r[`F_IRQ2_CODE]);
  end

  // A one-to-zero step of a selected tap, natural or forced, is a request
  always @*
  begin
    irq_nxt = sel_tap_q_r & ~cur_tap;
  end

  // Divider chain
  always @(posedge CLK)
  begin
    if (SRST)
    begin
      slow_q_r <= 1'b0;
      stage16_r <= 1'b0;
      upper_r <= 14'h0000;
      frac_r <= 21'h000000;
    end
    else
    begin
      slow_q_r <= SLOW_CLK;
      if (slow_fall)
      begin
        stage16_r <= !stage16_r;
      end
      upper_r <= upper_nxt;
      frac_r <= frac_nxt;
    end
  end

  // Previous selected taps, used to find falling edges
  always @(posedge CLK)
  begin
    if (SRST)
    begin
      sel_tap_q_r <= 3'h0;
    end
    else
    begin
      sel_tap_q_r <= cur_tap;
    end
  end

  // One-cycle request pulses to the interrupt controller
  always @(posedge CLK)
  begin
    if (SRST)
    begin
      PERIODIC_IRQ0 <= 1'b0;
      PERIODIC_IRQ1 <= 1'b0;
      PERIODIC_IRQ2 <= 1'b0;
    end
    else
    begin
      PERIODIC_IRQ0 <= irq_nxt[0];
      PERIODIC_IRQ1 <= irq_nxt[1];
      PERIODIC_IRQ2 <= irq_nxt[2];
    end
  end

  // Sticky status: a new event wins over a clear in the same cycle
  always @*
  begin
    status_nxt = status_r;
    if (clr_wr)
    begin
      status_nxt = status_r & ~PWDATA[2:0];
    end
    status_nxt = status_nxt | irq_nxt;
  end

  // Status and enable registers
  always @(posedge CLK)
  begin
    if (SRST)
    begin
      status_r <= 3'h0;
      enable_r <= `RST_IRQ_ENABLE;
    end
    else
    begin
      status_r <= status_nxt;
      if (en_wr)
      begin
        enable_r <= PWDATA[2:0];
      end
    end
  end

  // Level interrupt while any enabled status bit is set
  assign IRQ = |(status_r & enable_r);

  // Trim pair
  always @(posedge CLK)
  begin
    if (SRST)
    begin
      trim_r <= `RST_TRIM;
    end
    else
    begin
      if (trim_lo_wr)
      begin
        trim_r[7:0] <= PWDATA[7:0];
      end
      if (trim_hi_wr)
      begin
        trim_r[10:8] <= PWDATA[`F_TRIM_HIGH];
      end
    end
  end

  // Interrupt tap selects, reserved bits kept at zero
  always @(posedge CLK)
  begin
    if (SRST)
    begin
      sel_low_r <= `RST_IRQ_SEL_LOW;
      sel_high_r <= `RST_IRQ_SEL_HIGH;
    end
    else
    begin
      if (int_lo_wr)
      begin
        sel_low_r <= {1'b0, PWDATA[6:4], 1'b0, PWDATA[2:0]};
      end
      if (int_hi_wr)
      begin
        sel_high_r <= PWDATA[2:0];
      end
    end
  end

  // Read word for the addressed register, reserved bits zero
  always @*
  begin
    rd_word = 32'h00000000;
    if (sel_snap)
    begin
      rd_word[7:0] = slow_taps;
    end
    else if (sel_trim_lo)
    begin
      rd_word[7:0] = trim_r[7:0];
    end
    else if (sel_trim_hi)
    begin
      rd_word[2:0] = trim_r[10:8];
    end
    else if (sel_int_lo)
    begin
      rd_word[7:0] = sel_low_r;
    end
    else if (sel_int_hi)
    begin
      rd_word[2:0] = sel_high_r;
    end
    else if (sel_stat)
    begin
      rd_word[2:0] = status_r;
    end
    else if (sel_en)
    begin
      rd_word[2:0] = enable_r;
    end
  end

  // Read data flop, loaded in the setup phase so it stands through the access phase
  always @(posedge CLK)
  begin
    if (SRST)
    begin
      PRDATA <= 32'h00000000;
    end
    else if (setup_ph)
    begin
      PRDATA <= rd_word;
    end
  end

endmodule // slow_time_base

`default_nettype wire

// >>> verification/slow_time_base_properties.sv
// Port checker for the slow time base
`default_nettype none
module slow_time_base_properties (
  input wire logic CLK, SRST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, TAP_32K, TAP_16K, TAP_8K, IRQ,
  input wire logic PERIODIC_IRQ0, PERIODIC_IRQ1, PERIODIC_IRQ2,
  input wire logic [19:0] PADDR,
  input wire logic [31:0] PRDATA
);
  timeunit 1ns;
  timeprecision 1ps;
  // Completed write access
  wire wr = PSEL && PENABLE && PWRITE;
  // Shared clock and reset for every check
  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);
  // A request is one cycle high, then low
  sequence s_one(x); x ##1 !x; endsequence
  a_pulse_irq0: assert property (PERIODIC_IRQ0 |-> s_one(PERIODIC_IRQ0)) else $error("irq0 pulse long");
  a_pulse_irq1: assert property (PERIODIC_IRQ1 |-> s_one(PERIODIC_IRQ1)) else $error("irq1 pulse long");
  a_pulse_irq2: assert property (PERIODIC_IRQ2 |-> s_one(PERIODIC_IRQ2)) else $error("irq2 pulse long");
  a_pulse_cause: assert property (PERIODIC_IRQ0 && !$past(wr) |-> ##[0:1] !TAP_16K) else $error("stray irq0");
  a_tap16_step: assert property ($changed(TAP_16K) |-> !TAP_32K) else $error("16k off slow fall");
  a_tap8_step: assert property ($changed(TAP_8K) |-> !TAP_16K) else $error("8k off 16k fall");
  a_irq_rise: assert property ($rose(IRQ) |-> PERIODIC_IRQ0 || PERIODIC_IRQ1 || PERIODIC_IRQ2 || $past(wr))
    else $error("irq rose alone");
  a_irq_fall: assert property ($fell(IRQ) |-> $past(wr)) else $error("irq fell alone");
  a_snap_byte: assert property (PSEL && PENABLE && PADDR == 20'h3c180 |-> !PSLVERR && PRDATA[31:8] == 24'h0)
    else $error("snapshot word bad");
endmodule // slow_time_base_properties
bind slow_time_base slow_time_base_properties u_props (.*);
`default_nettype wire

// >>> verification/irq_flag_model.sv
// Interrupt controller model counting requests of line 0
`default_nettype none
module irq_flag_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic req,
  output logic [7:0] cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  // Flag lands one cycle after the request
  always @(posedge clk)
    cnt <= rst ? 8'h0 : cnt + 8'(req);
endmodule // irq_flag_model
`default_nettype wire

// >>> verification/tb_top.sv
// Self-checking bench for the slow time base
`include "slow_time_base_regs.vh"
`default_nettype none
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin failures++; $display("unexpected %s %h %h", n, e, a); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK = 0, SRST = 1, SLOW_CLK = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, er;
  logic [19:0] PADDR = 20'h0;
  logic [31:0] PWDATA = 32'h0, PRDATA, rd;
  logic PREADY, PSLVERR, TAP_32K, TAP_16K, TAP_8K, PERIODIC_IRQ0, PERIODIC_IRQ1, PERIODIC_IRQ2, IRQ;
  logic [1:0] ph = 2'h0;
  logic [7:0] cnt, c;
  int failures = 0, cmp_count = 0, cyc = 0, n;
  slow_time_base uut (.*);
  irq_flag_model fm (.clk(CLK), .rst(SRST), .req(PERIODIC_IRQ0), .cnt(cnt));
  // Clocks, slow clock of four cycles, and hang limit
  initial forever #2 CLK = ~CLK;
  always @(posedge CLK)
  begin
    ph <= ph + 2'h1;
    SLOW_CLK <= ph[1];
    cyc <= cyc + 1;
    if (cyc == 90000)
    begin
      failures++;
      final_report();
    end
  end
  // One APB transfer
  task automatic apb(input logic w, input logic [15:0] i, input logic [31:0] d);
    @(posedge CLK);
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA} <= {2'b10, w, 2'b00, i, 2'b00, d};
    @(posedge CLK);
    PENABLE <= 1'b1;
    do @(posedge CLK); while (PREADY !== 1'b1);
    {rd, er} = {PRDATA, PSLVERR};
    {PSEL, PENABLE} <= 2'b00;
  endtask
  task automatic wp();
    do @(posedge CLK); while (PERIODIC_IRQ0 !== 1'b1);
  endtask
  // Reset values, reserved trim bits, unmapped index
  task automatic t_regs();
    logic [15:0] ix [5] = '{`IDX_TAP_SNAPSHOT, `IDX_TRIM_LOW, `IDX_TRIM_HIGH, `IDX_IRQ_SEL_LOW, `IDX_IRQ_SEL_HIGH};
    logic [7:0] ev [5] = '{8'h00, 8'h00, 8'h00, 8'h30, 8'h06};
    for (int k = 0; k < 5; k++)
    begin
      apb(1'b0, ix[k], 32'h0);
      `CHK("reset", ev[k], rd[7:0])
    end
    apb(1'b1, `IDX_TRIM_HIGH, 32'hff);
    apb(1'b0, `IDX_TRIM_HIGH, 32'h0);
    `CHK("trim high", 8'h07, rd[7:0])
    apb(1'b1, `IDX_TRIM_HIGH, 32'h0);
    apb(1'b1, `IDX_TRIM_LOW, 32'h1ff);
    apb(1'b0, `IDX_TRIM_LOW, 32'h0);
    `CHK("trim low", 32'hff, rd)
    apb(1'b1, `IDX_TRIM_LOW, 32'h0);
    apb(1'b0, 16'hf061, 32'h0);
    `CHK("unmapped", 33'h100000000, {er, rd})
  endtask
  // Snapshot write while 128 Hz is high forces a request
  task automatic t_snap();
    apb(1'b1, `IDX_IRQ_ENABLE, 32'h0);
    do apb(1'b0, `IDX_TAP_SNAPSHOT, 32'h0); while (rd[0] !== 1'b0);
    do apb(1'b0, `IDX_TAP_SNAPSHOT, 32'h0); while (rd[0] !== 1'b1);
    c = cnt;
    apb(1'b1, `IDX_TAP_SNAPSHOT, 32'ha5);
    repeat (3) @(posedge CLK);
    `CHK("forced irq", c + 8'h1, cnt)
    do
    begin
      apb(1'b0, `IDX_TAP_SNAPSHOT, 32'h0);
      c = rd[7:0];
      apb(1'b0, `IDX_TAP_SNAPSHOT, 32'h0);
    end while (rd[7:0] !== c);
    `CHK("snapshot", 8'h00, rd[7:0])
    apb(1'b1, `IDX_IRQ_CLEAR, 32'h7);
  endtask
  // Interval between requests for codes 0 to 3
  task automatic t_period();
    for (int k = 0; k < 4; k++)
    begin
      apb(1'b1, `IDX_IRQ_SEL_LOW, 32'h30 | k);
      repeat (2) wp();
      n = 0;
      do
      begin
        @(posedge CLK);
        n++;
      end while (PERIODIC_IRQ0 !== 1'b1);
      `CHK("interval", 1024 << k, n)
    end
  endtask
  // Summary interrupt set, cleared and masked
  task automatic t_irq();
    apb(1'b1, `IDX_IRQ_SEL_HIGH, 32'h0);
    apb(1'b1, `IDX_IRQ_ENABLE, 32'h4);
    do @(posedge CLK); while (IRQ !== 1'b1);
    apb(1'b0, `IDX_IRQ_STATUS, 32'h0);
    `CHK("status", 1'b1, rd[2])
    apb(1'b1, `IDX_IRQ_CLEAR, 32'h7);
    #1 `CHK("cleared", 1'b0, IRQ)
    apb(1'b1, `IDX_IRQ_ENABLE, 32'h0);
    wp();
    #1 `CHK("masked", 1'b0, IRQ)
  endtask
  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    repeat (16) @(posedge CLK);
    SRST <= 1'b0;
    t_regs();
    t_snap();
    t_period();
    t_irq();
    final_report();
  end
endmodule // tb_top
`default_nettype wire
